// *** design/irq_unit_consts.vh ***
`ifndef IRQ_UNIT_CONSTS_VH
`define IRQ_UNIT_CONSTS_VH

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define VEC_REMOTE  13'h0004
`define VEC_TIMER   13'h0003
`define VEC_VSYNC   13'h0002
`define VEC_SERIAL  13'h0001

// ------------------------------------------------------------
// Source bit positions in the flag vectors
// ------------------------------------------------------------
`define SRC_SERIAL  0
`define SRC_VSYNC   1
`define SRC_TIMER   2
`define SRC_REMOTE  3
`define SRC_COUNT   4

// ------------------------------------------------------------
// Stack geometry and reset values
// ------------------------------------------------------------
`define RAS_DEPTH   6
`define ISTK_DEPTH  2
`define SP_RESET    3'h6
`define PC_WIDTH    13

`endif

// *** design/return_address_stack.v ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Return address stack memory, registered read
// ------------------------------------------------------------
module return_address_stack #(
  parameter DEPTH = 6,
  parameter WIDTH = 13,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata_q
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// *** design/edge_select_sync.v ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Pin synchroniser with selectable edge detect
// ------------------------------------------------------------
module edge_select_sync (
  input  wire clk,
  input  wire sys_rst,
  input  wire pin,
  input  wire rise_sel,
  output reg  edge_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // s1 feeds only s2
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      edge_q <= rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
    end
  end
endmodule

// *** design/vectored_interrupt_unit.v ***
// Operation
// - Remote-control pin edge selectable, rising or falling.
// - Request flag sets on source request, clears on its acceptance.
// - Software write of 1 to a request flag acts as a request.
// - Request flag holds until accepted or software writes 0.
// - Acceptance clears only the accepted source's request flag.
// - Request flags cleared by power-on, clock-stop and chip-enable reset.
// - Active request needs permission and request; both read/writable.
// - Permission flags cleared by power-on, clock-stop, chip-enable reset.
// - Vectors: remote 04H, timer 03H, vsync 02H, serial 01H.
// - Global enable low means no acceptance.
// - Enable instruction takes effect after the following instruction.
// - Disable instruction clears global enable in its own cycle.
// - Acceptance clears the global enable flip-flop.
// - Repeated enable or disable leaves the flip-flop unchanged.
// - Global enable cleared by power-on, clock-stop, chip-enable reset.
// - Acceptance decrements stack pointer, then stores PC at new entry.
// - Return loads PC from entry at pointer, then increments pointer.
// - Acceptance pushes bank and index-enable, then clears both copies.
// - Interrupt stack holds two levels of bank and index-enable.
// - Return restores bank and index-enable from interrupt stack top.
// - Priority: DMA, remote pin, timer, vsync pin, serial last.
// - Flag clear, vector and PC save happen in one interrupt cycle.
// - Request flags set regardless of global enable and permission.
// - Only bank bits 1:0 and index-enable are saved.
`timescale 1ns/1ns
`include "irq_unit_consts.vh"
module vectored_interrupt_unit #(
  parameter PCW = `PC_WIDTH
) (
  input  wire           clk,
  input  wire           sys_rst,
  input  wire           instr_step,
  input  wire           clock_stop_exec,
  input  wire           chip_enable_reset,
  input  wire           remote_ctrl_input,
  input  wire           remote_rise_sel,
  input  wire           timer_req,
  input  wire           vsync_req,
  input  wire           serial_req,
  input  wire           dma_pending,
  input  wire           enable_irq_instruction,
  input  wire           disable_irq_instruction,
  input  wire           return_from_irq_instruction,
  input  wire [PCW-1:0] pc_current,
  input  wire [1:0]     bank_in,
  input  wire           index_enable_in,
  input  wire           req_wr,
  input  wire [3:0]     req_wdata,
  input  wire           perm_wr,
  input  wire [3:0]     perm_wdata,
  output reg  [3:0]     source_request_flag,
  output reg  [3:0]     source_permission_flag,
  output reg            global_irq_enable_ff,
  output reg            irq_cycle_q,
  output reg  [PCW-1:0] pc_load_q,
  output reg            pc_load_valid_q,
  output reg  [1:0]     bank_q,
  output reg            index_enable_flag,
  output reg            sysreg_load_q,
  output reg  [2:0]     sp_q,
  output reg  [1:0]     istk_level_q
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Highest priority active source as a one-hot grant
  function [3:0] pick;
    input [3:0] act;
    begin
      if (act[`SRC_REMOTE])
        pick = 4'h8;
      else if (act[`SRC_TIMER])
        pick = 4'h4;
      else if (act[`SRC_VSYNC])
        pick = 4'h2;
      else if (act[`SRC_SERIAL])
        pick = 4'h1;
      else
        pick = 4'h0;
    end
  endfunction

  function [PCW-1:0] vec_of;
    input [3:0] g;
    begin
      case (g)
        4'h8:    vec_of = `VEC_REMOTE;
        4'h4:    vec_of = `VEC_TIMER;
        4'h2:    vec_of = `VEC_VSYNC;
        default: vec_of = `VEC_SERIAL;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Requests and acceptance
  // ------------------------------------------------------------
  wire       remote_edge;
  wire       soft_clr;
  wire [3:0] hw_req;
  wire [3:0] active;
  wire [3:0] grant;
  wire       accept;
  wire [2:0] sp_dec;
  wire [PCW-1:0] ras_rdata;

  edge_select_sync u_remote (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin      (remote_ctrl_input),
    .rise_sel (remote_rise_sel),
    .edge_q   (remote_edge)
  );

  // Clock stop and chip-enable reset act as synchronous clears
  assign soft_clr = clock_stop_exec | chip_enable_reset;
  assign hw_req   = {remote_edge, timer_req, vsync_req, serial_req};
  assign active   = source_request_flag & source_permission_flag;
  // DMA outranks every source, so it holds acceptance off
  assign grant    = pick(active);
  assign accept   = instr_step & global_irq_enable_ff & (|active)
                    & ~dma_pending & ~irq_cycle_q;
  assign sp_dec   = sp_q - 3'h1;

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      source_request_flag    <= 4'h0;
      source_permission_flag <= 4'h0;
    end
    else if (soft_clr)
    begin
      source_request_flag    <= 4'h0;
      source_permission_flag <= 4'h0;
    end
    else
    begin
      // A write of 1 is a request; new requests win over acceptance and write-0 clears
      source_request_flag <=
        (req_wr ? req_wdata : source_request_flag & ~(accept ? grant :
        4'h0)) | hw_req;
      if (perm_wr)
      begin
        source_permission_flag <= perm_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Global enable
  // ------------------------------------------------------------
  reg en_pend_q;
  reg en_arm_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      global_irq_enable_ff <= 1'b0;
      en_pend_q            <= 1'b0;
      en_arm_q             <= 1'b0;
    end
    else if (soft_clr)
    begin
      global_irq_enable_ff <= 1'b0;
      en_pend_q            <= 1'b0;
      en_arm_q             <= 1'b0;
    end
    else if (disable_irq_instruction | accept)
    begin
      // Disable also cancels an enable still in flight
      global_irq_enable_ff <= 1'b0;
      en_pend_q            <= 1'b0;
      en_arm_q             <= 1'b0;
    end
    else if (instr_step)
    begin
      if (en_arm_q)
      begin
        global_irq_enable_ff <= 1'b1;
        en_arm_q             <= 1'b0;
      end
      en_pend_q <= 1'b0;
      // An enable pulse on the boundary ends its own instruction here
      if (en_pend_q | enable_irq_instruction)
      begin
        en_arm_q <= 1'b1;
      end
    end
    else if (enable_irq_instruction)
    begin
      en_pend_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Return address stack
  // ------------------------------------------------------------
  reg       ret_pend_q;
  reg [2:0] ras_raddr;

  always @*
  begin
    ras_raddr = sp_q;
  end

  return_address_stack #(
    .DEPTH (`RAS_DEPTH),
    .WIDTH (PCW),
    .AW    (3)
  ) u_ras (
    .clk     (clk),
    .we      (accept),
    .waddr   (sp_dec),
    .wdata   (pc_current),
    .raddr   (ras_raddr),
    .rdata_q (ras_rdata)
  );

  // ------------------------------------------------------------
  // Interrupt stack
  // ------------------------------------------------------------
  reg [2:0] istk_q [0:`ISTK_DEPTH-1];
  wire      do_ret;

  // The interrupt cycle takes the slot, so a colliding return is dropped
  assign do_ret = return_from_irq_instruction & ~ret_pend_q & ~accept;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      istk_q[0]    <= 3'h0;
      istk_q[1]    <= 3'h0;
      istk_level_q <= 2'h0;
    end
    else if (accept)
    begin
      // Push; a third level overwrites the oldest
      istk_q[1]    <= istk_q[0];
      istk_q[0]    <= {bank_in, index_enable_in};
      if (istk_level_q != 2'h2)
        istk_level_q <= istk_level_q + 2'h1;
    end
    else if (do_ret)
    begin
      istk_q[0] <= istk_q[1];
      if (istk_level_q != 2'h0)
        istk_level_q <= istk_level_q - 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Sequencer outputs
  // ------------------------------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sp_q              <= `SP_RESET;
      irq_cycle_q       <= 1'b0;
      pc_load_q         <= {PCW{1'b0}};
      pc_load_valid_q   <= 1'b0;
      bank_q            <= 2'h0;
      index_enable_flag <= 1'b0;
      sysreg_load_q     <= 1'b0;
      ret_pend_q        <= 1'b0;
    end
    else
    begin
      irq_cycle_q     <= accept;
      pc_load_valid_q <= 1'b0;
      sysreg_load_q   <= 1'b0;
      ret_pend_q      <= do_ret;
      if (accept)
      begin
        sp_q              <= sp_dec;
        pc_load_q         <= vec_of(grant);
        pc_load_valid_q   <= 1'b1;
        bank_q            <= 2'h0;
        index_enable_flag <= 1'b0;
        sysreg_load_q     <= 1'b1;
      end
      else if (do_ret)
      begin
        bank_q            <= istk_q[0][2:1];
        index_enable_flag <= istk_q[0][0];
        sysreg_load_q     <= 1'b1;
      end
      else if (ret_pend_q)
      begin
        // Memory read is registered, so the PC arrives a cycle later
        pc_load_q       <= ras_rdata;
        pc_load_valid_q <= 1'b1;
        sp_q            <= sp_q + 3'h1;
      end
    end
  end
endmodule

// *** dv/vectored_interrupt_unit_asserts.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module irq_unit_asserts #(
  parameter PCW = 13
) (
  input wire           clk,
  input wire           sys_rst,
  input wire           instr_step,
  input wire           clock_stop_exec,
  input wire           chip_enable_reset,
  input wire           dma_pending,
  input wire           disable_irq_instruction,
  input wire [3:0]     source_request_flag,
  input wire [3:0]     source_permission_flag,
  input wire           global_irq_enable_ff,
  input wire           irq_cycle_q,
  input wire [PCW-1:0] pc_load_q,
  input wire [1:0]     bank_q,
  input wire           index_enable_flag,
  input wire [2:0]     sp_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [3:0] act = source_request_flag & source_permission_flag;
  wire [2:0] v3 = act[3] ? 3'h4 : act[2] ? 3'h3 : act[1] ? 3'h2 : 3'h1;
  wire [PCW-1:0] vec = {{(PCW-3){1'b0}}, v3};

  dis_clr_a: assert property (
    disable_irq_instruction |=> !global_irq_enable_ff)
    else $error("enable held after disable");
  en_edge_a: assert property (
    $rose(global_irq_enable_ff) |-> $past(instr_step))
    else $error("enable set off a boundary");
  no_acc_a: assert property (
    !global_irq_enable_ff |=> !irq_cycle_q)
    else $error("accepted while disabled");
  acc_cause_a: assert property (
    irq_cycle_q |-> $past(instr_step && |act && !dma_pending))
    else $error("accept without cause");
  acc_vec_a: assert property (
    irq_cycle_q |-> pc_load_q == $past(vec))
    else $error("wrong vector");
  acc_sp_a: assert property (
    irq_cycle_q |-> sp_q == $past(sp_q) - 3'h1)
    else $error("stack pointer not decremented");
  acc_sys_a: assert property (
    irq_cycle_q |-> !global_irq_enable_ff && bank_q == 2'h0
      && !index_enable_flag)
    else $error("state not cleared on accept");
  stop_clr_a: assert property (
    clock_stop_exec || chip_enable_reset |=> source_request_flag == 4'h0
      && source_permission_flag == 4'h0 && !global_irq_enable_ff)
    else $error("flags survive stop");
endmodule

// *** dv/cpu_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Instruction sequencer stand-in
// ----------------------------------------
module cpu_model #(
  parameter STEP = 4
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        pc_load_valid_q,
  input  wire [12:0] pc_load_q,
  output reg         instr_step,
  output reg  [12:0] pc_current
);
  reg [3:0] cnt_q;
  // PC moves only on loads, so saved addresses are easy to predict
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      instr_step <= 1'b0;
      pc_current <= 13'h0100;
    end
    else
    begin
      cnt_q <= (cnt_q == STEP - 1) ? 4'h0 : cnt_q + 4'h1;
      instr_step <= (cnt_q == STEP - 1);
      if (pc_load_valid_q)
        pc_current <= pc_load_q;
    end
  end
endmodule

// *** dv/test_vectored_interrupt_unit.sv ***
`timescale 1ns/1ns
module test_vectored_interrupt_unit;
  localparam PCW = 13;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg clock_stop_exec, chip_enable_reset, remote_ctrl_input, remote_rise_sel;
  reg timer_req, vsync_req, serial_req, dma_pending, req_wr, perm_wr;
  reg enable_irq_instruction, disable_irq_instruction;
  reg return_from_irq_instruction, index_enable_in;
  reg [1:0] bank_in;
  reg [3:0] req_wdata, perm_wdata;
  wire instr_step, global_irq_enable_ff, irq_cycle_q, pc_load_valid_q;
  wire sysreg_load_q, index_enable_flag;
  wire [PCW-1:0] pc_current, pc_load_q;
  wire [3:0] source_request_flag, source_permission_flag;
  wire [1:0] bank_q, istk_level_q;
  wire [2:0] sp_q;
  int mismatches = 0;
  int n_checks = 0;
  int d = 0;
  int i;
  int k;
  reg [31:0] seed = 32'h60A2;
  reg [PCW-1:0] exp_q[$];
  reg [PCW-1:0] rpc[2];
  reg [2:0] rsys[2];

  vectored_interrupt_unit #(.PCW(PCW)) dut (.*);
  cpu_model #(.STEP(4)) cpu (.*);

  always #5 clk = ~clk;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task check(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait: 0 boundary, 1 interrupt cycle, 2 state reload
  task wt(input int s);
    int n;
    begin
      n = 0;
      @(posedge clk);
      while ((s == 0 ? instr_step : s == 1 ? irq_cycle_q
              : sysreg_load_q) !== 1'b1)
      begin
        n++;
        if (n > 99)
        begin
          mismatches++;
          test_done;
        end
        @(posedge clk);
      end
    end
  endtask

  // Instruction pulse in the first cycle after a boundary
  task ins(input int c);
    wt(0);
    {enable_irq_instruction, disable_irq_instruction,
     return_from_irq_instruction} <= 3'h4 >> c;
    @(posedge clk);
    {enable_irq_instruction, disable_irq_instruction,
     return_from_irq_instruction} <= 3'h0;
  endtask

  task accept(input [2:0] v);
    rsys[d] = {index_enable_in, bank_in};
    exp_q.push_back({10'h0, v});
    wt(1);
    rpc[d] = pc_current;
    check(source_request_flag & (4'h1 << (v - 1)), 0);
    check(sp_q, 3'h5 - d);
    d++;
  endtask

  task ret;
    ins(2);
    d--;
    exp_q.push_back(rpc[d]);
    wt(2);
    check({index_enable_flag, bank_q}, rsys[d]);
    repeat (2) @(posedge clk);
    check(sp_q, 3'h6 - d);
  endtask

  // Every loaded PC is matched against the oldest expectation
  always @(posedge clk)
    if (pc_load_valid_q === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'h1, 16'h0);
      else
        check(pc_load_q, exp_q.pop_front());
    end

  initial
  begin
    {clock_stop_exec, chip_enable_reset, remote_ctrl_input, remote_rise_sel,
     timer_req, vsync_req, serial_req, dma_pending, req_wr, perm_wr,
     enable_irq_instruction, disable_irq_instruction,
     return_from_irq_instruction, index_enable_in, bank_in} = 0;
    {req_wdata, perm_wdata} = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(sp_q, 3'h6);
    check({source_request_flag, source_permission_flag}, 0);
    for (i = 0; i < 5; i++)
    begin
      k = i > 3 ? 3 : i;
      seed = xs(seed);
      {index_enable_in, bank_in} <= seed[2:0];
      remote_rise_sel <= (i == 3);
      @(posedge clk);
      case (i)
        0: serial_req <= 1'b1;
        1: vsync_req <= 1'b1;
        2: timer_req <= 1'b1;
        default: remote_ctrl_input <= (i == 3);
      endcase
      @(posedge clk);
      {timer_req, vsync_req, serial_req} <= 3'h0;
      repeat (8) @(posedge clk);
      check(source_request_flag, 4'h1 << k);
      perm_wr <= 1'b1;
      perm_wdata <= 4'h1 << k;
      ins(0);
      perm_wr <= 1'b0;
      wt(0);
      @(posedge clk);
      check(global_irq_enable_ff, 0);
      accept(k + 1);
      ret;
    end
    // DMA holds off acceptance, then priority and nesting
    dma_pending <= 1'b1;
    {req_wr, perm_wr, req_wdata, perm_wdata} <= {2'h3, 8'hFF};
    ins(0);
    {req_wr, perm_wr} <= 2'h0;
    repeat (3) wt(0);
    check(global_irq_enable_ff, 1);
    check(source_permission_flag, 4'hF);
    dma_pending <= 1'b0;
    accept(4);
    check(source_request_flag, 4'h7);
    ins(0);
    accept(3);
    check(istk_level_q, 2);
    ret;
    ret;
    ins(1);
    ins(1);
    check(global_irq_enable_ff, 0);
    {req_wr, req_wdata} <= 5'h10;
    @(posedge clk);
    req_wr <= 1'b0;
    @(posedge clk);
    check(source_request_flag, 0);
    for (i = 0; i < 2; i++)
    begin
      {req_wr, perm_wr, req_wdata, perm_wdata} <= {2'h3, 8'hFF};
      @(posedge clk);
      {req_wr, perm_wr} <= 2'h0;
      {clock_stop_exec, chip_enable_reset} <= 2'h1 << i;
      @(posedge clk);
      {clock_stop_exec, chip_enable_reset} <= 2'h0;
      @(posedge clk);
      check({source_request_flag, source_permission_flag}, 0);
    end
    repeat (4) @(posedge clk);
    check(exp_q.size(), 0);
    test_done;
  end
endmodule

bind vectored_interrupt_unit irq_unit_asserts #(.PCW(PCW)) chk (.*);
